// >>> design/crc_control.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: Comparator enable bit 7 of control/status switches the comparator.
// RULE2: Edge flag bit 6 is set on the edge kind chosen by sense select.
// RULE3: Edge flag sets two clocks after the output state bit changes.
// RULE4: Writing zero clears the edge flag; writing one leaves it alone.
// RULE5: Output pin enable bit 4 lets the result drive the external pin.
// RULE6: Output state bit 3 follows the synchronised comparator output.
// RULE7: Output state bit reads zero after reset and while disabled.
// RULE8: Sense code 00 both edges, 01 falling, 10 rising, 11 none.
// RULE9: Interrupt enable bit 0 gates the edge flag onto the interrupt.
// RULE10: Bits 6:4 pick the positive input; 111 is the reference output.
// RULE11: Bits 2:0 pick the negative input with the same encoding.
// RULE12: Software should not select the same input on both sides.
// RULE13: Reference generator enable bit 7 starts or stops the generator.
// RULE14: Reference source bit 6 picks internal reference or supply.
// RULE15: Level bits 4:0 give code plus one thirty-seconds of input.
// RULE16: Pad enable bits 6:0 allow each pin as an analog input.
// RULE17: Reset returns defaults with comparator and generator disabled.
// RULE18: Software sets input selection before enabling the comparator.
// RULE19: Interrupt is flag and enable; a new edge beats a clear. The code also ORs istQ & ienQ into irq.
module crc_control
    import crc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CRC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmpOutRaw,
    output crc_analog_t analogCtrl,
    output logic pinOut,
    output logic pinOe,
    output logic irq
);

    logic preadyQ;
    logic pslverrQ;
    logic [31:0] prdataQ;
    logic [7:0] csQ;
    logic [7:0] selQ;
    logic [7:0] refQ;
    logic [6:0] padQ;
    logic [IRQ_N-1:0] istQ;
    logic [IRQ_N-1:0] ienQ;
    logic sync1Q;
    logic sync2Q;
    logic stateQ;
    logic statePrevQ;
    logic edgeHitQ;
    logic flagQ;
    logic pinOutQ;
    logic irqQ;

    // Bus decode.
    wire logic [2:0] regIdx = paddr[CRC_AW-1:2];
    wire logic alignOk = (paddr[1:0] == 2'h0);
    wire logic mapped = alignOk && (regIdx <= CRC_IDX_IEN);
    wire logic accessPh = psel && penable;
    wire logic answerNow = accessPh && !preadyQ;
    wire logic done = accessPh && preadyQ;
    wire logic wrOk = done && pwrite && mapped;
    wire logic wrCs = wrOk && (regIdx == CRC_IDX_CS);
    wire logic wrSel = wrOk && (regIdx == CRC_IDX_SEL);
    wire logic wrRef = wrOk && (regIdx == CRC_IDX_REF);
    wire logic wrPad = wrOk && (regIdx == CRC_IDX_PAD);
    wire logic wrIclr = wrOk && (regIdx == CRC_IDX_ICLR);
    wire logic wrIen = wrOk && (regIdx == CRC_IDX_IEN);

    // Field views.
    wire logic cmpEn = csQ[CS_EN];
    wire logic pinEn = csQ[CS_OPE];
    wire logic edgeIe = csQ[CS_IE];
    wire crc_edge_t sense = crc_edge_t'(csQ[CS_SENSE_HI:CS_SENSE_LO]);

    // Edge qualification on the synchronised state bit.
    wire logic rise = stateQ && !statePrevQ;
    wire logic fall = !stateQ && statePrevQ;
    wire logic qualify = ((sense == CRC_EDGE_BOTH) && (rise || fall)) // RULE8
        || ((sense == CRC_EDGE_FALL) && fall)
        || ((sense == CRC_EDGE_RISE) && rise);

    // A write of one to the flag position leaves it as it was.
    wire logic flagClr = wrCs && !pwdata[CS_FLAG]; // RULE4

    wire logic [7:0] csRd = {csQ[CS_EN], flagQ, 1'b0, csQ[CS_OPE],
        stateQ, csQ[CS_SENSE_HI:CS_SENSE_LO], csQ[CS_IE]};

    logic [7:0] rdMux;
    always_comb begin
        unique case (regIdx)
            CRC_IDX_CS: rdMux = csRd;
            CRC_IDX_SEL: rdMux = selQ;
            CRC_IDX_REF: rdMux = refQ;
            CRC_IDX_PAD: rdMux = {1'b0, padQ};
            CRC_IDX_IST: rdMux = {{(8-IRQ_N){1'b0}}, istQ};
            CRC_IDX_IEN: rdMux = {{(8-IRQ_N){1'b0}}, ienQ};
            default: rdMux = 8'h00;
        endcase
    end

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preadyQ <= 1'b0;
            pslverrQ <= 1'b0;
            prdataQ <= 32'h0000_0000;
        end else begin
            preadyQ <= answerNow;
            pslverrQ <= answerNow && !mapped;
            if (answerNow && !pwrite && mapped) begin
                prdataQ <= {24'h00_0000, rdMux};
            end else begin
                prdataQ <= 32'h0000_0000;
            end
        end
    end

    // Software configuration; reset leaves everything disabled.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csQ <= CRC_RST_REG; // RULE17
            selQ <= CRC_RST_REG;
            refQ <= CRC_RST_REG;
            padQ <= CRC_RST_REG[6:0];
            ienQ <= '0;
        end else begin
            if (wrCs) begin
                csQ <= pwdata[7:0] & 8'h97; // RULE1 RULE5 RULE9
            end
            if (wrSel) begin
                selQ <= pwdata[7:0] & 8'h77; // RULE10 RULE11
            end
            if (wrRef) begin
                refQ <= pwdata[7:0] & 8'hDF; // RULE13 RULE14 RULE15
            end
            if (wrPad) begin
                padQ <= pwdata[PAD_HI:0]; // RULE16
            end
            if (wrIen) begin
                ienQ <= pwdata[IRQ_N-1:0];
            end
        end
    end

    // The first synchroniser stage feeds only the second one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1Q <= 1'b0;
            sync2Q <= 1'b0;
            stateQ <= 1'b0;
            statePrevQ <= 1'b0;
        end else begin
            sync1Q <= cmpOutRaw;
            sync2Q <= sync1Q;
            stateQ <= cmpEn ? sync2Q : 1'b0; // RULE6 RULE7
            statePrevQ <= stateQ;
        end
    end

    // The extra edge stage gives the documented two-clock lag to the flag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edgeHitQ <= 1'b0;
            flagQ <= 1'b0;
        end else begin
            edgeHitQ <= qualify; // RULE3
            if (edgeHitQ) begin
                flagQ <= 1'b1; // RULE2 RULE19
            end else if (flagClr) begin
                flagQ <= 1'b0;
            end
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    wire logic [IRQ_N-1:0] evt = {stateQ != statePrevQ, edgeHitQ};
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_N; gi++) begin : g_ist
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    istQ[gi] <= 1'b0;
                end else if (evt[gi]) begin
                    istQ[gi] <= 1'b1;
                end else if (wrIclr && pwdata[gi]) begin
                    istQ[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // The pin carries the result only while its enable is set.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinOutQ <= 1'b0;
            irqQ <= 1'b0;
        end else begin
            pinOutQ <= pinEn && stateQ; // RULE5
            irqQ <= (flagQ && edgeIe) || |(istQ & ienQ); // RULE9 RULE19
        end
    end

    // Mirrors of registers; software must set selections before enabling.
    assign analogCtrl.cmpEnable = csQ[CS_EN]; // RULE1 RULE18
    assign analogCtrl.posSel = selQ[SEL_POS_HI:SEL_POS_LO]; // RULE10 RULE12
    assign analogCtrl.negSel = selQ[SEL_NEG_HI:SEL_NEG_LO]; // RULE11
    assign analogCtrl.refgenEnable = refQ[REF_EN]; // RULE13
    assign analogCtrl.refgenSrc = refQ[REF_SRC]; // RULE14
    assign analogCtrl.refgenLevel = refQ[REF_LVL_HI:REF_LVL_LO]; // RULE15
    assign analogCtrl.padEnable = padQ; // RULE16
    assign pinOut = pinOutQ;
    assign pinOe = pinEn;
    assign irq = irqQ;
    assign prdata = prdataQ;
    assign pready = preadyQ;
    assign pslverr = pslverrQ;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence csWrite;
        wrCs;
    endsequence

    sequence qualifiedEdge;
        qualify && !edgeHitQ;
    endsequence

    sequence anyEdge;
        rise || fall;
    endsequence

    chk_enable_write: assert property ( // RULE1
        csWrite |=> analogCtrl.cmpEnable == $past(pwdata[CS_EN]))
        else $error("comparator enable did not follow the write");

    chk_flag_lag: assert property ( // RULE3
        qualifiedEdge |-> ##2 flagQ)
        else $error("edge flag not set two clocks after the edge");

    chk_flag_one_write: assert property ( // RULE4
        (wrCs && pwdata[CS_FLAG] && !edgeHitQ) |=> flagQ == $past(flagQ))
        else $error("writing one changed the edge flag");

    chk_pin_gate: assert property ( // RULE5
        !pinEn |=> !pinOut)
        else $error("pin carried the result while disabled");

    chk_state_off: assert property ( // RULE7
        !cmpEn [*2] |=> !stateQ)
        else $error("state bit set while comparator disabled");

    chk_fall_only: assert property ( // RULE8
        (sense == CRC_EDGE_FALL && rise && !flagQ && !edgeHitQ)
        |-> ##2 !flagQ)
        else $error("rising edge set the flag in falling mode");

    chk_irq_path: assert property ( // RULE9
        (flagQ && edgeIe) |=> irq)
        else $error("enabled edge flag gave no interrupt");

    chk_set_wins: assert property ( // RULE19
        (edgeHitQ && flagClr) |=> flagQ)
        else $error("clear beat a coincident edge");

    chk_sel_write: assert property ( // RULE10
        wrSel |=> analogCtrl.posSel == $past(pwdata[SEL_POS_HI:SEL_POS_LO]))
        else $error("positive select did not follow the write");

    // The edge pipeline is checked from the state bit back to the raw input, then stage by stage.
    chk_sync_lag: assert property ( // RULE6
        cmpEn [*3] |=> stateQ == $past(cmpOutRaw, 3))
        else $error("state bit did not follow the comparator output");

    chk_state_track: assert property ( // RULE6
        cmpEn |=> stateQ == $past(sync2Q))
        else $error("state bit did not follow the second stage");

    chk_flag_set: assert property ( // RULE2
        edgeHitQ |=> flagQ)
        else $error("qualified edge did not set the flag");

    chk_flag_clear: assert property ( // RULE4
        (flagClr && !edgeHitQ) |=> !flagQ)
        else $error("writing zero did not clear the edge flag");

    chk_both_fall: assert property ( // RULE8
        ((sense == CRC_EDGE_BOTH) && fall) |-> ##2 flagQ)
        else $error("falling edge missed in both-edge mode");

    chk_rise_only: assert property ( // RULE8
        ((sense == CRC_EDGE_RISE) && fall) |=> !edgeHitQ)
        else $error("falling edge qualified in rising mode");

    chk_rsvd_sense: assert property ( // RULE8
        (sense == CRC_EDGE_RSVD) ##0 anyEdge |=> !edgeHitQ)
        else $error("reserved sense code qualified an edge");

    chk_pin_follow: assert property ( // RULE5
        pinEn |=> pinOut == $past(stateQ))
        else $error("enabled pin did not carry the result");

    chk_irq_off: assert property ( // RULE9
        (!edgeIe && !(|(istQ & ienQ))) |=> !irq)
        else $error("interrupt raised with every source masked");

    chk_status_irq: assert property (
        (|(istQ & ienQ)) |=> irq)
        else $error("enabled status bit gave no interrupt");

    chk_neg_write: assert property ( // RULE11
        wrSel |=> analogCtrl.negSel == $past(pwdata[SEL_NEG_HI:SEL_NEG_LO]))
        else $error("negative select did not follow the write");

    chk_refgen_write: assert property ( // RULE13 RULE14
        wrRef |=> (analogCtrl.refgenEnable == $past(pwdata[REF_EN]))
            && (analogCtrl.refgenSrc == $past(pwdata[REF_SRC])))
        else $error("reference control did not follow the write");

    chk_level_write: assert property ( // RULE15
        wrRef |=> analogCtrl.refgenLevel
            == $past(pwdata[REF_LVL_HI:REF_LVL_LO]))
        else $error("reference level did not follow the write");

    chk_pad_write: assert property ( // RULE16
        wrPad |=> analogCtrl.padEnable == $past(pwdata[PAD_HI:0]))
        else $error("pad enables did not follow the write");

    chk_reset_idle: assert property ( // RULE17
        @(posedge clk) disable iff (1'b0)
        !rst_n |=> !analogCtrl.cmpEnable && !analogCtrl.refgenEnable)
        else $error("reset left the comparator or generator enabled");

endmodule : crc_control

`default_nettype wire

// >>> design/crc_pkg.sv
package crc_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [2:0] CRC_IDX_CS = 3'h0;
    localparam logic [2:0] CRC_IDX_SEL = 3'h1;
    localparam logic [2:0] CRC_IDX_REF = 3'h2;
    localparam logic [2:0] CRC_IDX_PAD = 3'h3;
    localparam logic [2:0] CRC_IDX_IST = 3'h4;
    localparam logic [2:0] CRC_IDX_ICLR = 3'h5;
    localparam logic [2:0] CRC_IDX_IEN = 3'h6;
    localparam int CRC_AW = 5;

    // Control and status field positions.
    localparam int CS_EN = 7;
    localparam int CS_FLAG = 6;
    localparam int CS_OPE = 4;
    localparam int CS_STATE = 3;
    localparam int CS_SENSE_HI = 2;
    localparam int CS_SENSE_LO = 1;
    localparam int CS_IE = 0;

    // Input select, reference control and pad field positions.
    localparam int SEL_POS_HI = 6;
    localparam int SEL_POS_LO = 4;
    localparam int SEL_NEG_HI = 2;
    localparam int SEL_NEG_LO = 0;
    localparam int REF_EN = 7;
    localparam int REF_SRC = 6;
    localparam int REF_LVL_HI = 4;
    localparam int REF_LVL_LO = 0;
    localparam int PAD_HI = 6;

    // Interrupt status bits.
    localparam int IRQ_EDGE = 0;
    localparam int IRQ_TOGGLE = 1;
    localparam int IRQ_N = 2;

    localparam logic [7:0] CRC_RST_REG = 8'h00;

    typedef enum logic [1:0] {
        CRC_EDGE_BOTH = 2'b00,
        CRC_EDGE_FALL = 2'b01,
        CRC_EDGE_RISE = 2'b10,
        CRC_EDGE_RSVD = 2'b11
    } crc_edge_t;

    typedef struct packed {
        logic cmpEnable;
        logic [2:0] posSel;
        logic [2:0] negSel;
        logic refgenEnable;
        logic refgenSrc;
        logic [4:0] refgenLevel;
        logic [6:0] padEnable;
    } crc_analog_t;

endpackage : crc_pkg

// >>> test/crc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module crc_analog_model
    import crc_pkg::*;
#(
    parameter int VREF_INT = 384,
    parameter int VSUPPLY = 1024
)(
    input wire crc_analog_t ctrl,
    input wire logic [6:0][9:0] extV,
    output logic cmpOutRaw
);
    int vin;
    int vgen;
    // A pin whose pad is not enabled reads as ground to the comparator.
    function automatic int pick(input logic [2:0] s);
        if (s == 3'h7) begin
            return vgen;
        end
        return ctrl.padEnable[s] ? int'(extV[s]) : 0;
    endfunction : pick
    always_comb begin
        vin = ctrl.refgenSrc ? VSUPPLY : VREF_INT;
        vgen = ctrl.refgenEnable ?
            (ctrl.refgenLevel + 1) * vin / 32 : 0;
        cmpOutRaw = ctrl.cmpEnable
            && (pick(ctrl.posSel) > pick(ctrl.negSel));
    end
endmodule : crc_analog_model
`default_nettype wire

// >>> test/tb_crc_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_crc_control;
    import crc_pkg::*;
    typedef struct packed {
        logic [4:0] a;
        logic [7:0] wd;
        logic [7:0] rd;
        logic err;
    } crc_row_t;
    localparam int NROW = 10;
    localparam crc_row_t ROWS [NROW] = '{
        '{5'h04, 8'hFF, 8'h77, 1'b0}, '{5'h08, 8'hFF, 8'hDF, 1'b0},
        '{5'h0C, 8'hFF, 8'h7F, 1'b0}, '{5'h00, 8'h5F, 8'h17, 1'b0},
        '{5'h10, 8'hFF, 8'h00, 1'b0}, '{5'h14, 8'hFF, 8'h00, 1'b0},
        '{5'h18, 8'hFF, 8'h03, 1'b0}, '{5'h18, 8'h00, 8'h00, 1'b0},
        '{5'h1C, 8'hFF, 8'h00, 1'b1}, '{5'h01, 8'hFF, 8'h00, 1'b1}
    };
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [4:0] paddr = 5'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmpOutRaw;
    crc_analog_t analogCtrl;
    logic pinOut;
    logic pinOe;
    logic irq;
    logic [6:0][9:0] extV = '0;
    logic [31:0] rdQ;
    logic errQ;
    int n_tests = 0;
    int n_mismatch = 0;

    crc_control dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmpOutRaw(cmpOutRaw),
        .analogCtrl(analogCtrl), .pinOut(pinOut), .pinOe(pinOe),
        .irq(irq));
    crc_analog_model model (.ctrl(analogCtrl), .extV(extV),
        .cmpOutRaw(cmpOutRaw));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic complete_run;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic checkReg(input string n, input logic [31:0] e,
                            input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : checkReg

    task automatic checkBit(input string n, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : checkBit

    task automatic apb(input logic [4:0] a, input logic w,
                       input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            complete_run();
        end
        rdQ = prdata;
        errQ = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic doReset;
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        checkBit("irq", 1'b0, irq);
        checkReg("analog", 32'h0, 32'(analogCtrl));
        for (int i = 0; i < 7; i++) begin
            apb(5'(i * 4), 1'b0, 8'h00);
            checkReg("reset value", 32'h0, rdQ);
        end
        $display("reset test done");
    endtask : doReset

    initial begin
        #500000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        doReset();
        for (int i = 0; i < NROW; i++) begin
            apb(ROWS[i].a, 1'b1, ROWS[i].wd);
            checkBit("write error", ROWS[i].err, errQ);
            apb(ROWS[i].a, 1'b0, 8'h00);
            checkReg("read", {24'h0, ROWS[i].rd},
                rdQ);
            checkBit("read error", ROWS[i].err, errQ);
        end
        $display("register rows done");
        // Inputs are chosen, distinct, before the comparator is enabled.
        apb(5'h04, 1'b1, 8'h07);
        apb(5'h08, 1'b1, 8'h8F);
        apb(5'h0C, 1'b1, 8'h01);
        apb(5'h00, 1'b0, 8'h00);
        for (int c = 0; c < 4; c++) begin
            logic [1:0] s;
            logic [7:0] cfg;
            s = 2'(c);
            cfg = {3'b100, s[0], 1'b0, s, 1'b1};
            apb(5'h00, 1'b1, cfg);
            // The write lands on the edge that ends the task; let it settle.
            @(negedge clk);
            checkReg("analog", 32'(crc_analog_t'{1'b1, 3'h0, 3'h7, 1'b1,
                1'b0, 5'h0F, 7'h01}), 32'(analogCtrl));
            checkBit("pin enable", s[0], pinOe);
            @(posedge clk);
            extV[0] <= 10'd300;
            repeat (6) @(posedge clk);
            checkBit("irq early", 1'b0, irq);
            @(posedge clk);
            checkBit("irq", s == 2'b00 || s == 2'b10,
                irq);
            checkBit("pin", s[0], pinOut);
            apb(5'h00, 1'b0, 8'h00);
            checkReg("status", {24'h0, cfg | {1'b0, !s[0], 6'h08}},
                rdQ);
            apb(5'h00, 1'b1, cfg | 8'h40);
            extV[0] <= 10'd100;
            repeat (8) @(posedge clk);
            apb(5'h00, 1'b0, 8'h00);
            checkReg("status", {24'h0, cfg | {1'b0, s != 2'b11, 6'h00}},
                rdQ);
        end
        $display("edge tests done");
        apb(5'h14, 1'b1, 8'h03);
        apb(5'h18, 1'b1, 8'h01);
        apb(5'h00, 1'b1, 8'h80);
        apb(5'h10, 1'b0, 8'h00);
        checkReg("int status", 32'h0, rdQ);
        @(posedge clk);
        extV[0] <= 10'd300;
        repeat (8) @(posedge clk);
        checkBit("irq status", 1'b1, irq);
        apb(5'h10, 1'b0, 8'h00);
        checkReg("int status", 32'h3, rdQ);
        apb(5'h14, 1'b1, 8'h01);
        repeat (2) @(posedge clk);
        checkBit("irq cleared", 1'b0, irq);
        apb(5'h18, 1'b1, 8'h02);
        repeat (2) @(posedge clk);
        checkBit("irq enabled", 1'b1, irq);
        apb(5'h18, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        checkBit("irq masked", 1'b0, irq);
        // A clear that lands with a new edge must lose to that edge.
        @(posedge clk);
        extV[0] <= 10'd100;
        @(posedge clk);
        apb(5'h00, 1'b1, 8'h80);
        apb(5'h00, 1'b0, 8'h00);
        checkReg("set wins", 32'h0000_00C0, rdQ);
        apb(5'h00, 1'b1, 8'h00);
        apb(5'h00, 1'b0, 8'h00);
        checkBit("state off", 1'b0, rdQ[3]);
        $display("interrupt test done");
        doReset();
        complete_run();
    end
endmodule : tb_crc_control
`default_nettype wire
